// ---- dv/mpg_cpu_model.sv ----
`timescale 1ns/1ns
module mpg_cpu_model (
	input wire logic clk_sys,
	input wire logic req,
	input wire logic [8:0] fields,
	output mpg_pkg::mpg_access_t cpu_access
);
	import mpg_pkg::*;
	logic [8:0] stale_reg = '0;
	// Idle fields flip each cycle
	always_ff @(posedge clk_sys)
		stale_reg <= ~cpu_access[8:0];
	assign cpu_access = req ? {1'b1, fields} : {1'b0, stale_reg};
endmodule : mpg_cpu_model

// ---- dv/mpg_guard_properties.sv ----
`timescale 1ns/1ns
module mpg_guard_properties
	import mpg_pkg::*;
#(
	parameter int unsigned WDOG_CYCLES = 50,
	parameter int unsigned CNT_W = 20
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire mpg_pkg::mpg_access_t cpu_access,
	input wire mpg_pkg::mpg_ctrl_t cpu_ctrl,
	input wire logic shield_intact,
	input wire logic illegal_instr,
	input wire logic protect_on_reg,
	input wire logic access_grant_reg,
	input wire logic access_deny_reg,
	input wire logic chip_reset_req_reg,
	input wire logic halt_reg,
	input wire logic [5:0] fault_cause_reg
);
	logic pv;
	logic rq;
	logic clr;
	assign pv = protect_on_reg && cpu_access.valid;
	assign rq = chip_reset_req_reg;
	assign clr = cpu_ctrl.irq_taken || (cpu_ctrl.priv_call && cpu_ctrl.target_call_relief)
		|| (cpu_ctrl.priv_return && cpu_ctrl.target_return_relief);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_open;
		!protect_on_reg && cpu_access.valid && !rq |=> access_grant_reg && !access_deny_reg;
	endproperty
	a_open: assert property (p_open) else $error("open access refused");
	property p_os;
		pv && cpu_access.area inside {MPG_OS_STACK, MPG_OS_WORK} |=> access_deny_reg;
	endproperty
	a_os: assert property (p_os) else $error("os area reached");
	property p_app;
		pv && cpu_access.write && cpu_access.area == MPG_APP |=> access_deny_reg;
	endproperty
	a_app: assert property (p_app) else $error("app write passed");
	property p_sys;
		pv && cpu_access.area == MPG_GPR && cpu_access.gpr_index == 4'hf |=> access_deny_reg;
	endproperty
	a_sys: assert property (p_sys) else $error("system reg reached");
	property p_set;
		!protect_on_reg && cpu_ctrl.set_protect && !rq |=> protect_on_reg || rq;
	endproperty
	a_set: assert property (p_set) else $error("protect not set");
	property p_off;
		$fell(protect_on_reg) |-> $past(clr) || rq;
	endproperty
	a_off: assert property (p_off) else $error("protect cleared");
	property p_ill;
		illegal_instr && !rq |=> rq && fault_cause_reg[2];
	endproperty
	a_ill: assert property (p_ill) else $error("illegal not reset");
	property p_pulse;
		$rose(rq) |-> rq[*4];
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse short");
	property p_halt;
		!shield_intact |=> halt_reg;
	endproperty
	a_halt: assert property (p_halt) else $error("no halt");
endmodule : mpg_guard_properties

bind mpg_guard mpg_guard_properties #(.WDOG_CYCLES(WDOG_CYCLES), .CNT_W(CNT_W)) u_chk (.*);

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
	import mpg_pkg::*;
	logic clk_sys = 0, sys_rst = 1, req = 0, kick = 1, ill = 0, iclk = 0, rclk = 0, cl = 0;
	logic shield = 1, cop = 0, odd = 0, prot, grant, deny, crr, halt;
	logic [7:0] f = 0;
	logic [5:0] cause;
	mpg_ctrl_t ctrl = '0;
	mpg_access_t ca;
	int mismatches = 0, num_checks = 0, ih = 8, rh = 20;
	// Rows: write, area, register index, denied when protected
	logic [8:0] rows [9] = '{9'h100, 9'h021, 9'h141, 9'h061, 9'h080, 9'h181, 9'h1a6,
		9'h0bf, 9'h1c1};
	always #2 clk_sys = ~clk_sys;
	always #ih iclk = ~iclk;
	always #rh rclk = ~rclk;
	mpg_cpu_model CPU (.clk_sys(clk_sys), .req(req), .fields({f, odd}), .cpu_access(ca));
	mpg_guard #(.WDOG_CYCLES(50)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_access(ca),
		.cpu_ctrl(ctrl), .cop_ram_enable(cop), .wdog_kick(kick), .illegal_instr(ill),
		.internal_clock(iclk), .rf_clock(rclk), .contactless_mode(cl), .shield_intact(shield),
		.protect_on_reg(prot), .access_grant_reg(grant), .access_deny_reg(deny),
		.chip_reset_req_reg(crr), .halt_reg(halt), .fault_cause_reg(cause));
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [6:0] g, input logic [6:0] e);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic acc(input logic [8:0] r, input logic e);
		@(negedge clk_sys);
		f = r[8:1];
		req = 1;
		@(negedge clk_sys);
		req = 0;
		chk({grant, deny}, {!e, e});
	endtask : acc
	task automatic ctl(input logic [5:0] c, input logic e);
		@(negedge clk_sys);
		ctrl = c;
		@(negedge clk_sys);
		ctrl = '0;
		chk(prot, e);
	endtask : ctl
	task automatic flt(input logic [5:0] e);
		int n;
		for (n = 0; n < 80 && crr !== 1'b1; n++)
			@(negedge clk_sys);
		chk({crr, cause}, {1'b1, e});
		ih = 8;
		rh = 20;
		ill = 0;
		odd = 0;
		req = 0;
		kick = 1;
		shield = 1;
		for (n = 0; n < 40 && crr !== 1'b0; n++)
			@(negedge clk_sys);
		chk(crr, 1'b0);
	endtask : flt
	initial
	begin
		#20000;
		mismatches++;
		summarize();
	end
	initial
	begin
		repeat (16) @(negedge clk_sys);
		sys_rst = 0;
		chk(prot, 1'b0);
		foreach (rows[i])
			acc(rows[i], 1'b0);
		ctl(6'h20, 1'b1);
		foreach (rows[i])
			acc(rows[i], rows[i][0]);
		cop = 1;
		acc(rows[3], 1'b0);
		ctl(6'h20, 1'b1);
		ctl(6'h10, 1'b1);
		ctl(6'h14, 1'b0);
		ctl(6'h20, 1'b1);
		ctl(6'h0a, 1'b0);
		ctl(6'h20, 1'b1);
		ctl(6'h01, 1'b0);
		// Mid-run reset while protected
		ctl(6'h20, 1'b1);
		sys_rst = 1;
		@(negedge clk_sys);
		sys_rst = 0;
		chk(prot, 1'b0);
		@(negedge clk_sys);
		ill = 1;
		flt(6'h04);
		odd = 1;
		req = 1;
		flt(6'h02);
		kick = 0;
		flt(6'h01);
		ih = 4;
		flt(6'h08);
		rh = 8;
		repeat (30) @(negedge clk_sys);
		// Latched cause still from the internal clock fault
		chk({crr, cause}, {1'b0, 6'h08});
		cl = 1;
		rh = 8;
		flt(6'h10);
		shield = 0;
		@(negedge clk_sys);
		chk(halt, 1'b1);
		flt(6'h20);
		summarize();
	end
endmodule : tb_top

// ---- logic/mpg_defines.svh ----
`ifndef MPG_DEFINES_SVH
`define MPG_DEFINES_SVH

// Memory area codes presented with each CPU access
`define MPG_AREA_RAM 3'h0
`define MPG_AREA_OS_STACK 3'h1
`define MPG_AREA_OS_WORK 3'h2
`define MPG_AREA_COP_RAM 3'h3
`define MPG_AREA_APP 3'h4
`define MPG_AREA_GPR 3'h5
`define MPG_AREA_OTHER 3'h6

// Index of the system control register among the general purpose registers
`define MPG_SYSREG_INDEX 4'hf

// Protection status after reset: off (permissive)
`define MPG_PROT_RESET 1'b0

// Fault source bit positions in the latched cause vector
`define MPG_CAUSE_WDOG 0
`define MPG_CAUSE_ODD 1
`define MPG_CAUSE_ILL 2
`define MPG_CAUSE_ICLK 3
`define MPG_CAUSE_RFCLK 4
`define MPG_CAUSE_SHIELD 5

// Chip reset request pulse length, in clock cycles
`define MPG_RST_PULSE 4'h4

// Watchdog timeout, system clock period and minimum clock phases, in ns
`define MPG_WDOG_TIMEOUT_NS 1000000
`define MPG_CLK_PERIOD_NS 4
`define MPG_ICLK_MIN_PHASE_NS 8
`define MPG_RFCLK_MIN_PHASE_NS 20

`endif

// ---- logic/mpg_guard.sv ----
`timescale 1ns/1ns
`include "mpg_defines.svh"

// Overview of operation
// - Protected: RAM ok except OS areas; COP RAM only if enabled
// - Protected: other areas denied; application read only
// - Protected: registers ok except system register
// - Protection set only from unprotected software
// - Privileged call into relief clears protection
// - Privileged return into relief clears protection
// - Taken interrupt clears protection, as does chip reset
// - Watchdog timeout forces chip reset
// - Odd address access forces chip reset
// - Illegal instruction forces chip reset
// - Short internal clock phase forces reset
// - Short RF clock phase, contactless only
// - Broken active shield stops the device
// - Reset leaves protection off
module mpg_guard #(
	parameter int unsigned WDOG_CYCLES =
		`MPG_WDOG_TIMEOUT_NS / `MPG_CLK_PERIOD_NS,
	parameter int unsigned CNT_W = 20
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire mpg_pkg::mpg_access_t cpu_access,
	input wire mpg_pkg::mpg_ctrl_t cpu_ctrl,
	input wire logic cop_ram_enable,
	input wire logic wdog_kick,
	input wire logic illegal_instr,
	input wire logic internal_clock,
	input wire logic rf_clock,
	input wire logic contactless_mode,
	input wire logic shield_intact,
	output logic protect_on_reg,
	output logic access_grant_reg,
	output logic access_deny_reg,
	output logic chip_reset_req_reg,
	output logic halt_reg,
	output logic [5:0] fault_cause_reg
);
	import mpg_pkg::*;

	localparam int unsigned ICLK_MIN_CYC =
		(`MPG_ICLK_MIN_PHASE_NS + `MPG_CLK_PERIOD_NS - 1) / `MPG_CLK_PERIOD_NS;
	localparam int unsigned RFCLK_MIN_CYC =
		(`MPG_RFCLK_MIN_PHASE_NS + `MPG_CLK_PERIOD_NS - 1) / `MPG_CLK_PERIOD_NS;
	localparam int unsigned PH_W = 8;

	// Access decision for a single request under the given status
	function automatic logic allowed(input mpg_access_t a, input logic prot, input logic cop_en);
		logic ok;
		ok = 1'b1;
		if (prot)
		begin
			unique case (a.area)
				`MPG_AREA_RAM: ok = 1'b1;
				`MPG_AREA_OS_STACK: ok = 1'b0;
				`MPG_AREA_OS_WORK: ok = 1'b0;
				`MPG_AREA_COP_RAM: ok = cop_en;
				`MPG_AREA_APP: ok = !a.write;
				`MPG_AREA_GPR: ok = (a.gpr_index != `MPG_SYSREG_INDEX);
				default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction : allowed

	// Phase length check: true when a completed phase was too short
	function automatic logic phase_short(input logic [PH_W-1:0] len, input int unsigned min_cyc);
		return ({24'h0, len} < min_cyc);
	endfunction : phase_short

	logic [CNT_W-1:0] wdog_cnt_reg;
	logic [PH_W-1:0] iph_reg;
	logic [PH_W-1:0] rph_reg;
	logic iclk_q_reg;
	logic rclk_q_reg;
	logic iclk_seen_reg;
	logic rclk_seen_reg;
	logic [3:0] pulse_cnt_reg;
	mpg_state_t state_reg;
	logic [5:0] fault_now;
	logic iclk_fault;
	logic rclk_fault;

	// Protection status
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			protect_on_reg <= `MPG_PROT_RESET;
		else if (state_reg == MPG_RESETTING)
			protect_on_reg <= `MPG_PROT_RESET;
		else if (protect_on_reg)
		begin
			if (cpu_ctrl.irq_taken)
				protect_on_reg <= 1'b0;
			else if (cpu_ctrl.priv_call && cpu_ctrl.target_call_relief)
				protect_on_reg <= 1'b0;
			else if (cpu_ctrl.priv_return && cpu_ctrl.target_return_relief)
				protect_on_reg <= 1'b0;
		end
		else if (cpu_ctrl.set_protect)
			protect_on_reg <= 1'b1;
	end

	// Access verdict, one cycle after the request
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			access_grant_reg <= 1'b0;
			access_deny_reg <= 1'b0;
		end
		else
		begin
			access_grant_reg <= cpu_access.valid &&
				allowed(cpu_access, protect_on_reg, cop_ram_enable);
			access_deny_reg <= cpu_access.valid &&
				!allowed(cpu_access, protect_on_reg, cop_ram_enable);
		end
	end

	// Watchdog
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			wdog_cnt_reg <= '0;
		else if (wdog_kick || state_reg == MPG_RESETTING)
			wdog_cnt_reg <= '0;
		else if (wdog_cnt_reg != CNT_W'(WDOG_CYCLES))
			wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
	end

	// Clock phase monitors
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			iclk_q_reg <= 1'b0;
			rclk_q_reg <= 1'b0;
			iph_reg <= '0;
			rph_reg <= '0;
			iclk_seen_reg <= 1'b0;
			rclk_seen_reg <= 1'b0;
		end
		else
		begin
			iclk_q_reg <= internal_clock;
			rclk_q_reg <= rf_clock;
			if (internal_clock != iclk_q_reg)
			begin
				iph_reg <= 8'h1;
				iclk_seen_reg <= 1'b1;
			end
			else if (iph_reg != 8'hff)
				iph_reg <= iph_reg + 8'h1;
			if (rf_clock != rclk_q_reg)
			begin
				rph_reg <= 8'h1;
				rclk_seen_reg <= contactless_mode;
			end
			else if (rph_reg != 8'hff)
				rph_reg <= rph_reg + 8'h1;
		end
	end

	assign iclk_fault = iclk_seen_reg && (internal_clock != iclk_q_reg) &&
		phase_short(iph_reg, ICLK_MIN_CYC);
	assign rclk_fault = contactless_mode && rclk_seen_reg && (rf_clock != rclk_q_reg) &&
		phase_short(rph_reg, RFCLK_MIN_CYC);

	always_comb
	begin
		fault_now = '0;
		fault_now[`MPG_CAUSE_WDOG] = (wdog_cnt_reg == CNT_W'(WDOG_CYCLES));
		fault_now[`MPG_CAUSE_ODD] = cpu_access.valid && cpu_access.odd_addr;
		fault_now[`MPG_CAUSE_ILL] = illegal_instr;
		fault_now[`MPG_CAUSE_ICLK] = iclk_fault;
		fault_now[`MPG_CAUSE_RFCLK] = rclk_fault;
		fault_now[`MPG_CAUSE_SHIELD] = !shield_intact;
	end

	// Reset request sequencer
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= MPG_RUN;
			pulse_cnt_reg <= '0;
			chip_reset_req_reg <= 1'b0;
			fault_cause_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				MPG_RUN:
					if (|fault_now)
					begin
						state_reg <= MPG_RESETTING;
						pulse_cnt_reg <= `MPG_RST_PULSE;
						chip_reset_req_reg <= 1'b1;
						fault_cause_reg <= fault_now;
					end
				MPG_RESETTING:
					if (pulse_cnt_reg > 4'h1)
						pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
					else if (shield_intact)
					begin
						state_reg <= MPG_RUN;
						pulse_cnt_reg <= '0;
						chip_reset_req_reg <= 1'b0;
					end
			endcase
		end
	end

	// Stop while the shield reports broken
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			halt_reg <= 1'b0;
		else
			halt_reg <= !shield_intact;
	end

endmodule : mpg_guard

// ---- logic/mpg_pkg.sv ----
package mpg_pkg;

	typedef enum logic [2:0] {
		MPG_RAM,
		MPG_OS_STACK,
		MPG_OS_WORK,
		MPG_COP_RAM,
		MPG_APP,
		MPG_GPR,
		MPG_OTHER
	} mpg_area_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] area;
		logic [3:0] gpr_index;
		logic odd_addr;
	} mpg_access_t;

	typedef struct packed {
		logic set_protect;
		logic priv_call;
		logic priv_return;
		logic target_call_relief;
		logic target_return_relief;
		logic irq_taken;
	} mpg_ctrl_t;

	typedef enum logic {
		MPG_RUN,
		MPG_RESETTING
	} mpg_state_t;

endpackage : mpg_pkg
